/* design/sdram_dimm_pkg.sv */
// Constants, pin bundle and encodings shared by the memory module model.
// Assumes one 50 MHz clock and a synchronous active-high reset.
package sdram_dimm_pkg;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int ROW_W  = 12;
    localparam int COL_W  = 9;
    localparam int BANKS  = 4;
    localparam int DQ_W   = 72;
    localparam int LANE_W = 8;
    localparam int LANES  = 9;
    localparam int ARR_AW = 10;
    localparam int ARR_CB = 7;
    localparam int AP_BIT = 10;
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_W     = ARR_AW + LANES + DQ_W;
    localparam int LVL_W      = 5;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int T_RFC_NS      = 70;
    localparam int T_RFC_INT     = (T_RFC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0] T_RFC_CYC = 3'(T_RFC_INT);
    localparam logic [1:0] T_WR_CLK  = 2'h2;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    localparam int REG_AW = 8;
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_REFCNT = 8'h08;
    localparam int CTRL_BL_LSB     = 0;
    localparam int CTRL_CL_BIT     = 3;
    localparam int CTRL_UNLOCK_BIT = 4;
    localparam int ST_OPEN_LSB     = 0;
    localparam int ST_PDOWN_BIT    = 4;
    localparam int ST_RFBUSY_BIT   = 5;
    localparam int ST_OVF_BIT      = 6;
    localparam int ST_LEVEL_LSB    = 8;
    localparam logic [2:0] BL_1    = 3'h0;
    localparam logic [2:0] BL_2    = 3'h1;
    localparam logic [2:0] BL_4    = 3'h2;
    localparam logic [2:0] BL_8    = 3'h3;
    localparam logic [2:0] BL_FULL = 3'h7;
    localparam logic [2:0] BL_RESET = BL_8;

    // ------------------------------------------------------------
    // Presence store
    // ------------------------------------------------------------
    localparam int SPD_BYTES = 256;
    localparam logic [3:0] SPD_DEV_TYPE = 4'ha;
    localparam logic [3:0] I2C_ACK_BIT  = 4'h8;

    typedef enum logic [2:0] {
        CMD_LMR = 3'b000, CMD_REF = 3'b001, CMD_PRE = 3'b010, CMD_ACT = 3'b011,
        CMD_WR  = 3'b100, CMD_RD  = 3'b101, CMD_BST = 3'b110, CMD_NOP = 3'b111
    } cmd_t;

    typedef enum logic [2:0] {I2C_IDLE, I2C_DEV, I2C_WORD, I2C_WR, I2C_RD} i2c_st_t;

    typedef struct packed {
        logic              cke;
        logic              cs_n;
        logic              ras_n;
        logic              cas_n;
        logic              we_n;
        logic [1:0]        ba;
        logic [ROW_W-1:0]  addr;
        logic [LANES-1:0]  dqm;
        logic [DQ_W-1:0]   dq;
    } pin_t;

endpackage

/* design/sdram_dimm_access.sv */
// Memory module model: command decode, bank/burst engine, write FIFO,
// presence store on a two-wire bus and an AHB-Lite register slave.
// Assumes all pin inputs synchronous to clk_i (the module clock in).
//
// Summary of operation
// - Activate takes the bank from the two bank-select pins and the row from A0 to A11.
// - Read or write takes the first column from the address; later columns are made inside.
// - Burst length is 1, 2, 4, 8 or full page, and a terminate command ends a burst early.
// - With auto precharge the row closes by itself once a fixed-length burst has run its full length.
// - A new column command is taken on every cycle, so row accesses run back to back.
// - One bank may be precharged while another bank is still being accessed.
// - Command, address and data inputs are all sampled on the rising clock edge.
// - The presence store holds 256 bytes: lower half maker data, upper half for the user.
// - The presence store is a two-wire bus slave at one of eight addresses set by three pins.
// - In registered mode commands and addresses reach the memory one clock later.
// - Auto refresh and a low-power power-down state are entered on command.
// - Latch mode select high delays inputs one edge; low passes them in the same clock.
`timescale 1ns/1ps

// ------------------------------------------------------------
// Write data FIFO
// ------------------------------------------------------------
module data_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic                     clk_i,
    input  wire logic                     rst_i,
    input  wire logic                     in_valid_i,
    output logic                          in_ready_o,
    input  wire logic [WIDTH-1:0]         in_data_i,
    output logic                          out_valid_o,
    input  wire logic                     out_ready_i,
    output logic [WIDTH-1:0]              out_data_o,
    output logic [$clog2(DEPTH):0]        level_o
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

    // Pointers wrap naturally, so DEPTH must be a power of two
    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0]   cnt;
    } fifo_st_t;

    fifo_st_t         s;
    fifo_st_t         n;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             push;
    logic             pop;

    assign in_ready_o  = (s.cnt != FULL_CNT);
    assign out_valid_o = (s.cnt != '0);
    assign out_data_o  = mem[s.rp];
    assign level_o     = s.cnt;
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_comb begin
        n = s;
        if (push) begin
            n.wp = s.wp + 1'b1;
        end
        if (pop) begin
            n.rp = s.rp + 1'b1;
        end
        if (push && !pop) begin
            n.cnt = s.cnt + 1'b1;
        end else if (pop && !push) begin
            n.cnt = s.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
        end else begin
            s <= n;
        end
        if (push) begin
            mem[s.wp] <= in_data_i;
        end
    end
endmodule

// ------------------------------------------------------------
// Module top
// ------------------------------------------------------------
module sdram_dimm_access
    import sdram_dimm_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              hsel_i,
    input  wire logic [31:0]       haddr_i,
    input  wire logic [1:0]        htrans_i,
    input  wire logic              hwrite_i,
    input  wire logic [2:0]        hsize_i,
    input  wire logic [31:0]       hwdata_i,
    input  wire logic              hready_i,
    output logic [31:0]            hrdata_o,
    output logic                   hreadyout_o,
    output logic                   hresp_o,
    input  wire logic              cke_i,
    input  wire logic              cs_n_i,
    input  wire logic              ras_n_i,
    input  wire logic              cas_n_i,
    input  wire logic              we_n_i,
    input  wire logic [1:0]        ba_i,
    input  wire logic [ROW_W-1:0]  addr_i,
    input  wire logic [LANES-1:0]  dqm_i,
    input  wire logic [DQ_W-1:0]   dq_i,
    output logic [DQ_W-1:0]        dq_o,
    output logic                   dq_oe_n_o,
    input  wire logic              input_latch_mode_select_i,
    input  wire logic [2:0]        presence_store_slave_select_i,
    input  wire logic              scl_i,
    input  wire logic              sda_i,
    output logic                   sda_o,
    output logic                   sda_oe_n_o
);
    typedef struct packed {
        pin_t                         inr;
        logic [2:0]                   bl;
        logic                         cl;
        logic                         unlock;
        logic                         ap_valid;
        logic                         ap_write;
        logic [REG_AW-1:0]            ap_addr;
        logic [31:0]                  rdata;
        logic [BANKS-1:0]             open;
        logic [BANKS-1:0][ROW_W-1:0]  row;
        logic                         pdown;
        logic [2:0]                   rf_cnt;
        logic [15:0]                  ref_count;
        logic                         b_act;
        logic                         b_wr;
        logic                         b_ap;
        logic                         b_full;
        logic [1:0]                   b_bank;
        logic [COL_W-1:0]             b_col;
        logic [COL_W-1:0]             b_left;
        logic                         ap_pend;
        logic [1:0]                   ap_bank;
        logic [1:0]                   ap_cnt;
        logic [1:0]                   rp_v;
        logic [1:0][DQ_W-1:0]         rp_d;
        logic [DQ_W-1:0]              dq_q;
        logic                         dq_drv;
        logic                         ovf;
        logic                         scl_p;
        logic                         sda_p;
        i2c_st_t                      ist;
        logic [3:0]                   bitcnt;
        logic [7:0]                   sh;
        logic [7:0]                   out;
        logic [7:0]                   ptr;
        logic                         sda_low;
    } state_t;

    state_t              s;
    state_t              n;
    pin_t                raw;
    pin_t                p;
    cmd_t                cmd;
    logic [COL_W-1:0]    mask;
    logic                beat_v;
    logic                beat_wr;
    logic [1:0]          beat_bank;
    logic [COL_W-1:0]    beat_col;
    logic                rd_en;
    logic [ARR_AW-1:0]   arr_addr;
    logic [DQ_W-1:0]     arr_rdata;
    logic                push_ready;
    logic                drain_v;
    logic [FIFO_W-1:0]   drain_data;
    logic [LVL_W-1:0]    level;
    logic                take;
    logic                scl_rise;
    logic                scl_fall;
    logic                st_we;
    logic [DQ_W-1:0]     arr [1 << ARR_AW];
    logic [7:0]          store [SPD_BYTES];

    function automatic cmd_t decode_cmd(input pin_t x);
        if (x.cs_n || !x.cke) begin
            return CMD_NOP;
        end
        return cmd_t'({x.ras_n, x.cas_n, x.we_n});
    endfunction

    function automatic logic [COL_W-1:0] bl_mask(input logic [2:0] code);
        case (code)
            BL_1:    return 9'h000;
            BL_2:    return 9'h001;
            BL_4:    return 9'h003;
            BL_8:    return 9'h007;
            default: return 9'h1ff;
        endcase
    endfunction

    function automatic logic [COL_W-1:0] next_col(input logic [COL_W-1:0] c,
                                                  input logic [COL_W-1:0] m);
        return (c & ~m) | ((c + 9'h001) & m);
    endfunction

    assign raw = '{cke: cke_i, cs_n: cs_n_i, ras_n: ras_n_i, cas_n: cas_n_i, we_n: we_n_i,
                   ba: ba_i, addr: addr_i, dqm: dqm_i, dq: dq_i};
    // Row bit 0 plus seven column bits: rows and columns above alias
    assign arr_addr  = {beat_bank, s.row[beat_bank][0], beat_col[ARR_CB-1:0]};
    assign arr_rdata = arr[arr_addr];
    assign take      = hsel_i && hready_i && htrans_i[1];
    assign scl_rise  = scl_i && !s.scl_p;
    assign scl_fall  = !scl_i && s.scl_p;

    always_comb begin
        n = s;
        // ------------------------------------------------------------
        // Register writes
        // ------------------------------------------------------------
        n.ap_valid = take;
        n.ap_write = hwrite_i;
        n.ap_addr  = haddr_i[REG_AW-1:0];
        if (s.ap_valid && s.ap_write) begin
            case (s.ap_addr)
                REG_CTRL: begin
                    n.bl     = hwdata_i[CTRL_BL_LSB +: 3];
                    n.cl     = hwdata_i[CTRL_CL_BIT];
                    n.unlock = hwdata_i[CTRL_UNLOCK_BIT];
                end
                REG_STATUS: begin
                    if (hwdata_i[ST_OVF_BIT]) begin
                        n.ovf = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        // ------------------------------------------------------------
        // Command path
        // ------------------------------------------------------------
        p     = input_latch_mode_select_i ? s.inr : raw;
        n.inr = raw;
        cmd   = decode_cmd(p);
        mask  = bl_mask(s.bl);
        beat_v    = s.b_act;
        beat_wr   = s.b_wr;
        beat_bank = s.b_bank;
        beat_col  = s.b_col;
        if (p.cke) begin
            n.pdown = 1'b0;
        end else if (!s.b_act) begin
            n.pdown = 1'b1;
        end
        if (s.rf_cnt != '0) begin
            n.rf_cnt = s.rf_cnt - 1'b1;
        end
        if (s.ap_pend) begin
            if (s.ap_cnt == '0) begin
                n.open[s.ap_bank] = 1'b0;
                n.ap_pend = 1'b0;
            end else begin
                n.ap_cnt = s.ap_cnt - 1'b1;
            end
        end
        if (s.b_act) begin
            if (!s.b_full && s.b_left == '0) begin
                n.b_act = 1'b0;
                if (s.b_ap) begin
                    n.ap_pend = 1'b1;
                    n.ap_bank = s.b_bank;
                    n.ap_cnt  = s.b_wr ? T_WR_CLK : 2'h0;
                end
            end else begin
                n.b_col  = next_col(s.b_col, mask);
                n.b_left = s.b_left - 1'b1;
            end
        end
        // Refresh in progress swallows commands
        if (s.rf_cnt == '0) begin
            case (cmd)
                CMD_ACT: begin
                    n.open[p.ba] = 1'b1;
                    n.row[p.ba]  = p.addr;
                end
                CMD_RD, CMD_WR: begin
                    if (s.open[p.ba]) begin
                        beat_v    = 1'b1;
                        beat_wr   = (cmd == CMD_WR);
                        beat_bank = p.ba;
                        beat_col  = p.addr[COL_W-1:0];
                        n.b_act   = (mask != '0);
                        n.b_wr    = beat_wr;
                        n.b_bank  = p.ba;
                        n.b_full  = (s.bl == BL_FULL);
                        n.b_col   = next_col(p.addr[COL_W-1:0], mask);
                        n.b_left  = mask - 1'b1;
                        n.b_ap    = p.addr[AP_BIT];
                        if (mask == '0 && p.addr[AP_BIT]) begin
                            n.ap_pend = 1'b1;
                            n.ap_bank = p.ba;
                            n.ap_cnt  = beat_wr ? T_WR_CLK : 2'h0;
                        end
                    end
                end
                CMD_BST: begin
                    n.b_act = 1'b0;
                end
                CMD_PRE: begin
                    if (p.addr[AP_BIT]) begin
                        n.open = '0;
                    end else begin
                        n.open[p.ba] = 1'b0;
                    end
                    if (p.addr[AP_BIT] || p.ba == s.b_bank) begin
                        n.b_act = 1'b0;
                    end
                end
                CMD_REF: begin
                    if (s.open == '0) begin
                        n.rf_cnt    = T_RFC_CYC;
                        n.ref_count = s.ref_count + 16'h0001;
                    end
                end
                default: ;
            endcase
        end
        // ------------------------------------------------------------
        // Read pipeline and write overflow
        // ------------------------------------------------------------
        rd_en     = beat_v && !beat_wr;
        n.rp_v    = {s.rp_v[0], rd_en};
        n.rp_d    = {s.rp_d[0], arr_rdata};
        n.dq_q    = s.cl ? s.rp_d[1] : s.rp_d[0];
        n.dq_drv  = s.cl ? s.rp_v[1] : s.rp_v[0];
        if (beat_v && beat_wr && !push_ready) begin
            n.ovf = 1'b1;
        end
        // ------------------------------------------------------------
        // Presence store slave
        // ------------------------------------------------------------
        st_we   = 1'b0;
        n.scl_p = scl_i;
        n.sda_p = sda_i;
        if (scl_i && s.scl_p && s.sda_p && !sda_i) begin
            n.ist     = I2C_DEV;
            n.bitcnt  = '0;
            n.sda_low = 1'b0;
        end else if (scl_i && s.scl_p && !s.sda_p && sda_i) begin
            n.ist     = I2C_IDLE;
            n.sda_low = 1'b0;
        end else if (s.ist != I2C_IDLE) begin
            if (scl_rise) begin
                if (s.bitcnt == I2C_ACK_BIT) begin
                    n.bitcnt = '0;
                    if (s.ist == I2C_RD && sda_i) begin
                        n.ist = I2C_IDLE;
                    end
                end else begin
                    n.sh     = {s.sh[6:0], sda_i};
                    n.bitcnt = s.bitcnt + 1'b1;
                end
            end else if (scl_fall) begin
                n.sda_low = 1'b0;
                if (s.bitcnt == I2C_ACK_BIT) begin
                    case (s.ist)
                        I2C_DEV: begin
                            if (s.sh[7:1] == {SPD_DEV_TYPE, presence_store_slave_select_i}) begin
                                n.sda_low = 1'b1;
                                n.ist     = s.sh[0] ? I2C_RD : I2C_WORD;
                                n.out     = store[s.ptr];
                            end else begin
                                n.ist = I2C_IDLE;
                            end
                        end
                        I2C_WORD: begin
                            n.ptr     = s.sh;
                            n.sda_low = 1'b1;
                            n.ist     = I2C_WR;
                        end
                        I2C_WR: begin
                            // Maker half is read-only unless unlocked
                            st_we     = s.ptr[7] || s.unlock;
                            n.ptr     = s.ptr + 8'h01;
                            n.sda_low = 1'b1;
                        end
                        I2C_RD: begin
                            n.ptr = s.ptr + 8'h01;
                            n.out = store[s.ptr + 8'h01];
                        end
                        default: n.ist = I2C_IDLE;
                    endcase
                end else if (s.ist == I2C_RD) begin
                    n.sda_low = !s.out[7];
                    n.out     = {s.out[6:0], 1'b0};
                end
            end
        end
        // ------------------------------------------------------------
        // Register reads, taken from the updated state
        // ------------------------------------------------------------
        n.rdata = '0;
        if (take && !hwrite_i) begin
            case (haddr_i[REG_AW-1:0])
                REG_CTRL: begin
                    n.rdata[CTRL_BL_LSB +: 3]  = n.bl;
                    n.rdata[CTRL_CL_BIT]       = n.cl;
                    n.rdata[CTRL_UNLOCK_BIT]   = n.unlock;
                end
                REG_STATUS: begin
                    n.rdata[ST_OPEN_LSB +: BANKS]  = n.open;
                    n.rdata[ST_PDOWN_BIT]          = n.pdown;
                    n.rdata[ST_RFBUSY_BIT]         = (n.rf_cnt != '0);
                    n.rdata[ST_OVF_BIT]            = n.ovf;
                    n.rdata[ST_LEVEL_LSB +: LVL_W] = level;
                end
                REG_REFCNT: n.rdata[15:0] = n.ref_count;
                default: ;
            endcase
        end
    end

    // Reads stall the drain; a write closely followed by a read of the
    // same column may return the older word while it waits in the FIFO
    data_fifo #(
        .WIDTH (FIFO_W),
        .DEPTH (FIFO_DEPTH)
    ) u_wr_fifo (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .in_valid_i  (beat_v && beat_wr),
        .in_ready_o  (push_ready),
        .in_data_i   ({arr_addr, p.dqm, p.dq}),
        .out_valid_o (drain_v),
        .out_ready_i (!rd_en),
        .out_data_o  (drain_data),
        .level_o     (level)
    );

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s          <= '0;
            s.inr.cs_n <= 1'b1;
            s.inr.cke  <= 1'b1;
            s.bl       <= BL_RESET;
            s.scl_p    <= 1'b1;
            s.sda_p    <= 1'b1;
        end else begin
            s <= n;
        end
        if (drain_v && !rd_en) begin
            for (int g = 0; g < LANES; g++) begin
                if (!drain_data[DQ_W + g]) begin
                    arr[drain_data[FIFO_W-1 -: ARR_AW]][g*LANE_W +: LANE_W] <=
                        drain_data[g*LANE_W +: LANE_W];
                end
            end
        end
        if (st_we) begin
            store[s.ptr] <= s.sh;
        end
    end

    assign hrdata_o    = s.rdata;
    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;
    assign dq_o        = s.dq_q;
    assign dq_oe_n_o   = !s.dq_drv;
    assign sda_o       = 1'b0;
    assign sda_oe_n_o  = !s.sda_low;
endmodule

/* verif/sdram_dimm_access_chk.sv */
// Port assertions on the memory module top.
// Assumes only the top's ports; bound at the foot.
`timescale 1ns/1ps
module sdram_dimm_access_chk (
    input wire logic        clk_i, rst_i, hsel_i, hwrite_i, hready_i, hreadyout_o, hresp_o,
    input wire logic        cke_i, cs_n_i, ras_n_i, cas_n_i, we_n_i, dq_oe_n_o,
    input wire logic [31:0] haddr_i, hrdata_o,
    input wire logic [1:0]  htrans_i
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire       ahb_rd = hsel_i && hready_i && htrans_i[1] && !hwrite_i;
    wire       pin_rd = !cs_n_i && cke_i && {ras_n_i, cas_n_i, we_n_i} == 3'h5;
    wire [7:0] ra     = haddr_i[7:0];
    a_ready_high: assert property (hreadyout_o) else $error("ready low");
    a_resp_okay: assert property (!hresp_o) else $error("error response");
    a_read_lat: assert property ($fell(dq_oe_n_o) |->
        $past(pin_rd, 2) || $past(pin_rd, 3) || $past(pin_rd, 4)) else $error("read latency");
    a_idle_zero: assert property (!$past(ahb_rd) |-> hrdata_o == 32'h0)
        else $error("stray data");
    a_unmapped_zero: assert property (ahb_rd && !(ra inside {8'h00, 8'h04, 8'h08}) |=>
        hrdata_o == 32'h0) else $error("unmapped read");
    a_ctrl_spare: assert property (ahb_rd && ra == 8'h00 |=> hrdata_o[31:5] == 27'h0)
        else $error("ctrl spare");
    a_stat_spare: assert property (ahb_rd && ra == 8'h04 |=> hrdata_o[31:13] == 19'h0)
        else $error("status spare");
    a_cnt_spare: assert property (ahb_rd && ra == 8'h08 |=> hrdata_o[31:16] == 16'h0)
        else $error("count spare");
    c_beat: cover property ($fell(dq_oe_n_o));
    c_reg_rd: cover property (ahb_rd && ra == 8'h08);
    c_pin_rd: cover property (pin_rd);
endmodule
bind sdram_dimm_access sdram_dimm_access_chk u_chk (.*);

/* verif/host_ctl_model.sv */
// Host controller model on the command pins.
// Assumes calls just after a rising edge.
`timescale 1ns/1ps
module host_ctl_model
    import sdram_dimm_pkg::*;
(
    input  wire logic        clk_i,
    output logic             cke_o, cs_n_o, ras_n_o, cas_n_o, we_n_o,
    output logic [1:0]       ba_o,
    output logic [ROW_W-1:0] addr_o,
    output logic [LANES-1:0] dqm_o,
    output logic [DQ_W-1:0]  dq_o
);
    initial {cke_o, cs_n_o, ras_n_o, cas_n_o, we_n_o, ba_o, addr_o, dqm_o, dq_o} = {5'h17, 95'h0};
    // Caller orders activate, access, precharge
    task automatic issue(input cmd_t c, input logic [1:0] b, input logic [11:0] a,
                         input logic [71:0] d);
        {ras_n_o, cas_n_o, we_n_o} <= c;
        ba_o <= b;
        addr_o <= a;
        dq_o <= d;
        @(posedge clk_i);
    endtask
    // Released data shows the inverse, not a held value
    task automatic idle;
        {ras_n_o, cas_n_o, we_n_o} <= CMD_NOP;
        dq_o <= ~dq_o;
        @(posedge clk_i);
    endtask
endmodule

/* verif/sdram_dimm_access_tb_top.sv */
// Bench: register bus, command pins and read bursts.
// Assumes the host model and the bound checker.
`timescale 1ns/1ps
module sdram_dimm_access_tb_top;
    import sdram_dimm_pkg::*;
    logic clk_i = 0, rst_i = 1, hsel_i = 0, hwrite_i = 0, hreadyout_o, hresp_o, dq_oe_n_o;
    logic cke_i, cs_n_i, ras_n_i, cas_n_i, we_n_i, sda_o, sda_oe_n_o, scl_i = 1, sda_i = 1;
    logic input_latch_mode_select_i = 0;
    logic [31:0] haddr_i = 0, hwdata_i = 0, hrdata_o, rd;
    logic [2:0] hsize_i = 3'h2, presence_store_slave_select_i = 3'h0;
    logic [1:0] htrans_i = 0, ba_i;
    logic [ROW_W-1:0] addr_i;
    logic [LANES-1:0] dqm_i;
    logic [DQ_W-1:0] dq_i, dq_o;
    logic [31:0] rows [6][2] = '{'{32'h0, 32'h0}, '{32'h2, 32'h2}, '{32'h3, 32'h3},
        '{32'h7, 32'h7}, '{32'hffff_fff3, 32'h13}, '{32'h1, 32'h1}};
    wire hready_i = hreadyout_o;
    int failures = 0, check_count = 0;
    sdram_dimm_access u_dut (.*);
    host_ctl_model u_host (.clk_i(clk_i), .cke_o(cke_i), .cs_n_o(cs_n_i), .ras_n_o(ras_n_i),
        .cas_n_o(cas_n_i), .we_n_o(we_n_i), .ba_o(ba_i), .addr_o(addr_i), .dqm_o(dqm_i),
        .dq_o(dq_i));
    task automatic chk(input string n, input logic [71:0] e, input logic [71:0] s);
        check_count++;
        if (s !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel_i <= 1;
        htrans_i <= 2'h2;
        hwrite_i <= w;
        haddr_i <= {24'h0, a};
        do @(negedge clk_i); while (hreadyout_o !== 1'b1);
        @(posedge clk_i);
        htrans_i <= 2'h0;
        hwdata_i <= d;
        do @(negedge clk_i); while (hreadyout_o !== 1'b1);
        rd = hrdata_o;
        @(posedge clk_i);
    endtask
    task automatic i2c_put(input logic c, input logic d);
        {scl_i, sda_i} <= {c, d};
        repeat (2) @(posedge clk_i);
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial forever #10 clk_i = ~clk_i;
    initial begin
        #20000;
        failures++;
        complete_run();
    end
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 0;
        @(posedge clk_i);
        ahb(0, 8'h00, 32'h0);
        chk("ctrl reset", 32'h3, rd);
        foreach (rows[i]) begin
            ahb(1, 8'h00, rows[i][0]);
            ahb(0, 8'h00, 32'h0);
            chk("ctrl", rows[i][1], rd);
        end
        u_host.issue(CMD_ACT, 2'h0, 12'h005, 72'h0);
        u_host.issue(CMD_WR, 2'h0, 12'h004, {9{8'h5a}});
        u_host.issue(CMD_NOP, 2'h0, 12'h0, {9{8'ha5}});
        u_host.idle();
        repeat (4) @(posedge clk_i);
        u_host.issue(CMD_RD, 2'h0, 12'h404, 72'h0);
        u_host.idle();
        @(negedge clk_i) chk("beat 0", {9{8'h5a}}, dq_o);
        @(negedge clk_i) chk("beat 1", {9{8'ha5}}, dq_o);
        repeat (6) @(posedge clk_i);
        u_host.issue(CMD_RD, 2'h0, 12'h004, 72'h0);
        u_host.idle();
        repeat (5) @(negedge clk_i) chk("closed row", 1'b1, dq_oe_n_o);
        u_host.issue(CMD_ACT, 2'h2, 12'h0, 72'h0);
        u_host.idle();
        ahb(0, 8'h04, 32'h0);
        chk("open banks", 4'h4, rd[3:0]);
        u_host.issue(CMD_PRE, 2'h0, 12'h400, 72'h0);
        u_host.idle();
        u_host.issue(CMD_REF, 2'h0, 12'h0, 72'h0);
        u_host.idle();
        repeat (5) @(posedge clk_i);
        ahb(0, 8'h08, 32'h0);
        chk("refresh count", 32'h1, rd);
        ahb(0, 8'h0c, 32'h0);
        chk("unmapped", 32'h0, rd);
        ahb(1, 8'h00, 32'ha);
        input_latch_mode_select_i <= 1'b1;
        u_host.issue(CMD_ACT, 2'h0, 12'h005, 72'h0);
        u_host.issue(CMD_RD, 2'h0, 12'h004, 72'h0);
        u_host.issue(CMD_PRE, 2'h2, 12'h000, 72'h0);
        u_host.idle();
        @(negedge clk_i) chk("reg gap", 1'b1, dq_oe_n_o);
        @(negedge clk_i) chk("reg beat 0", {9{8'h5a}}, dq_o);
        @(negedge clk_i) chk("reg beat 1", {9{8'ha5}}, dq_o);
        @(negedge clk_i) chk("reg beat 2", 1'b0, dq_oe_n_o);
        rd[7:0] = {SPD_DEV_TYPE, 4'h0};
        i2c_put(1'b1, 1'b0);
        for (int i = 15; i >= 0; i--) i2c_put(!i[0], rd[i / 2]);
        i2c_put(1'b0, 1'b1);
        @(negedge clk_i) chk("presence ack", 1'b0, sda_oe_n_o);
        complete_run();
    end
endmodule
